// >>> can_rx_mask_pkg.sv
// package: register map, field layout and carrier types of the receive mask and buffer status unit
package can_rx_mask_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int NUM_BUF = 32;
	localparam int NUM_MASK = 3;

	// register word indices
	localparam logic [ADDR_W-1:0] OFS_MASK_SELECT = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_MASK0_SID = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_MASK0_EID = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_MASK1_SID = 4'h3;
	localparam logic [ADDR_W-1:0] OFS_MASK1_EID = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_MASK2_SID = 4'h5;
	localparam logic [ADDR_W-1:0] OFS_MASK2_EID = 4'h6;
	localparam logic [ADDR_W-1:0] OFS_FULL_LOW = 4'h7;
	localparam logic [ADDR_W-1:0] OFS_FULL_HIGH = 4'h8;
	localparam logic [ADDR_W-1:0] OFS_OVF_LOW = 4'h9;
	localparam logic [ADDR_W-1:0] OFS_OVF_HIGH = 4'hA;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'hB;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'hC;

	// field positions of the mask standard-identifier register
	localparam int MSID_SID_LSB = 5;
	localparam int MSID_MODE_BIT = 3;
	localparam int MSID_EIDHI_LSB = 0;
	// implemented bits: 15-5, 3, 1-0
	localparam logic [DATA_W-1:0] MSID_IMPL = 16'hFFEB;

	// mask source codes
	localparam logic [1:0] MSEL_SET0 = 2'h0;
	localparam logic [1:0] MSEL_SET1 = 2'h1;
	localparam logic [1:0] MSEL_SET2 = 2'h2;
	localparam logic [1:0] MSEL_RSVD = 2'h3;

	// interrupt status bit positions
	localparam int IRQ_STORED_BIT = 0;
	localparam int IRQ_OVF_BIT = 1;

	// reset values
	localparam logic [DATA_W-1:0] RST_MASK_SELECT = 16'h0000;
	localparam logic [DATA_W-1:0] RST_MASK = 16'h0000;
	localparam logic [NUM_BUF-1:0] RST_FLAGS = 32'h0000_0000;
	localparam logic [1:0] RST_IRQ = 2'h0;

	typedef struct packed {
		logic ide;
		logic [10:0] standard_identifier;
		logic [17:0] extended_identifier;
	} frame_t;

	typedef struct packed {
		logic filter_extended_enable;
		logic [10:0] standard_identifier;
		logic [17:0] extended_identifier;
	} filter_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_t;

endpackage

// >>> can_rx_mask_buf.sv
// receive acceptance masking for filters 8-15 plus receive buffer full/overflow status
// Functional notes
// - selector 00/01/10 picks mask set; 11 reserved
// - filter 15 selector high, filter 8 lowest
// - mask sid bit set compares, clear ignores
// - mask bits 1-0 gate extended bits 17:16
// - extended mask bits 15-0 gate low bits
// - mode bit set: frame type must match filter
// - mode bit clear: either type, masked ids equal
// - mask sid bits 4 and 2 read zero
// - storing into buffer sets its full flag
// - buffers 16-31 full flags in second register
// - hit to still-full buffer sets overflow flag
// - buffers 16-31 overflow flags in second register
// - every included bit must equal filter bit; eid bits count for extended frames only
// - filter extended enable picks accepted frame type when mode bit set
`timescale 1ns/1ps
`default_nettype none
module can_rx_mask_buf
	import can_rx_mask_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire can_rx_mask_pkg::reg_req_t req_i,
	output logic [can_rx_mask_pkg::DATA_W-1:0] rdata_o,
	input wire logic frame_valid_i,
	input wire can_rx_mask_pkg::frame_t frame_i,
	input wire logic [2:0] filter_num_i,
	input wire can_rx_mask_pkg::filter_t filter_i,
	input wire logic [4:0] target_buf_i,
	output logic accept_o,
	output logic store_o,
	output logic overflow_o,
	output logic [4:0] store_buf_o,
	output logic irq_o
);
	import can_rx_mask_pkg::*;

	typedef struct packed {
		logic [DATA_W-1:0] msel;
		logic [NUM_MASK-1:0][DATA_W-1:0] msid;
		logic [NUM_MASK-1:0][DATA_W-1:0] meid;
		logic [NUM_BUF-1:0] full;
		logic [NUM_BUF-1:0] ovf;
		logic [1:0] irq_stat;
		logic [1:0] irq_mask;
		logic [DATA_W-1:0] rdata;
		logic accept;
		logic store;
		logic overflow;
		logic [4:0] sbuf;
	} state_t;

	localparam state_t STATE_RST = '{
		msel: RST_MASK_SELECT,
		msid: {NUM_MASK{RST_MASK}},
		meid: {NUM_MASK{RST_MASK}},
		full: RST_FLAGS,
		ovf: RST_FLAGS,
		irq_stat: RST_IRQ,
		irq_mask: RST_IRQ,
		rdata: 16'h0000,
		accept: 1'b0,
		store: 1'b0,
		overflow: 1'b0,
		sbuf: 5'h00
	};

	state_t q;
	state_t d;

	// selector of filter 8+n sits at bits 2n+1:2n
	function automatic logic [1:0] mask_code(input logic [DATA_W-1:0] msel, input logic [2:0] n);
		return msel[{n, 1'b0} +: 2];
	endfunction

	// compare only where the mask is one; eid is looked at for extended frames only
	function automatic logic id_match(input frame_t f, input filter_t flt,
			input logic [DATA_W-1:0] ms, input logic [DATA_W-1:0] me);
		logic [10:0] sid_m;
		logic [17:0] eid_m;
		logic sid_ok;
		logic eid_ok;
		logic type_ok;
		sid_m = ms[DATA_W-1:MSID_SID_LSB];
		eid_m = {ms[MSID_EIDHI_LSB +: 2], me};
		sid_ok = ((f.standard_identifier ^ flt.standard_identifier) & sid_m) == 11'h000;
		eid_ok = ((f.extended_identifier ^ flt.extended_identifier) & eid_m) == 18'h00000;
		type_ok = !ms[MSID_MODE_BIT] || (f.ide == flt.filter_extended_enable);
		return type_ok && sid_ok && (!f.ide || eid_ok);
	endfunction

	logic [1:0] sel_c;
	logic mode_c;
	logic hit_c;
	logic was_full_c;
	logic [NUM_BUF-1:0] set_full;
	logic [NUM_BUF-1:0] set_ovf;
	logic [NUM_BUF-1:0] clr_full;
	logic [NUM_BUF-1:0] clr_ovf;
	logic [1:0] irq_ev;
	logic [DATA_W-1:0] rd_mux;

	always_comb begin
		d = q;
		sel_c = mask_code(q.msel, filter_num_i);
		mode_c = 1'b0;
		hit_c = 1'b0;
		// reserved code selects nothing, so the frame is not accepted
		if (sel_c != MSEL_RSVD) begin
			mode_c = q.msid[sel_c][MSID_MODE_BIT];
			hit_c = frame_valid_i && id_match(frame_i, filter_i, q.msid[sel_c], q.meid[sel_c]);
		end
		was_full_c = q.full[target_buf_i];

		set_full = '0;
		set_ovf = '0;
		if (hit_c && !was_full_c) begin
			set_full[target_buf_i] = 1'b1;
		end
		if (hit_c && was_full_c) begin
			set_ovf[target_buf_i] = 1'b1;
		end
		irq_ev = {|set_ovf, |set_full};

		// flag words are clear-only: a zero written clears, a one leaves the flag; the irq status word clears on a one
		clr_full = '0;
		clr_ovf = '0;
		if (req_i.wr) begin
			unique case (req_i.addr)
				OFS_MASK_SELECT: d.msel = req_i.wdata;
				OFS_MASK0_SID: d.msid[0] = req_i.wdata & MSID_IMPL;
				OFS_MASK0_EID: d.meid[0] = req_i.wdata;
				OFS_MASK1_SID: d.msid[1] = req_i.wdata & MSID_IMPL;
				OFS_MASK1_EID: d.meid[1] = req_i.wdata;
				OFS_MASK2_SID: d.msid[2] = req_i.wdata & MSID_IMPL;
				OFS_MASK2_EID: d.meid[2] = req_i.wdata;
				OFS_FULL_LOW: clr_full[15:0] = ~req_i.wdata;
				OFS_FULL_HIGH: clr_full[31:16] = ~req_i.wdata;
				OFS_OVF_LOW: clr_ovf[15:0] = ~req_i.wdata;
				OFS_OVF_HIGH: clr_ovf[31:16] = ~req_i.wdata;
				OFS_IRQ_STATUS: d.irq_stat = q.irq_stat & ~req_i.wdata[1:0];
				OFS_IRQ_MASK: d.irq_mask = req_i.wdata[1:0];
				default: ;
			endcase
		end
		// set after clear: an event landing on a clear is kept
		d.full = (q.full & ~clr_full) | set_full;
		d.ovf = (q.ovf & ~clr_ovf) | set_ovf;
		d.irq_stat = d.irq_stat | irq_ev;

		unique case (req_i.addr)
			OFS_MASK_SELECT: rd_mux = q.msel;
			OFS_MASK0_SID: rd_mux = q.msid[0];
			OFS_MASK0_EID: rd_mux = q.meid[0];
			OFS_MASK1_SID: rd_mux = q.msid[1];
			OFS_MASK1_EID: rd_mux = q.meid[1];
			OFS_MASK2_SID: rd_mux = q.msid[2];
			OFS_MASK2_EID: rd_mux = q.meid[2];
			OFS_FULL_LOW: rd_mux = q.full[15:0];
			OFS_FULL_HIGH: rd_mux = q.full[31:16];
			OFS_OVF_LOW: rd_mux = q.ovf[15:0];
			OFS_OVF_HIGH: rd_mux = q.ovf[31:16];
			OFS_IRQ_STATUS: rd_mux = {14'h0000, q.irq_stat};
			OFS_IRQ_MASK: rd_mux = {14'h0000, q.irq_mask};
			default: rd_mux = 16'h0000;
		endcase
		// read data appear for exactly one cycle after the read strobe
		d.rdata = req_i.rd ? rd_mux : 16'h0000;

		d.accept = hit_c;
		d.store = hit_c && !was_full_c;
		d.overflow = hit_c && was_full_c;
		d.sbuf = hit_c ? target_buf_i : q.sbuf;
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			q <= STATE_RST;
		end else begin
			q <= d;
		end
	end

	assign rdata_o = q.rdata;
	assign accept_o = q.accept;
	assign store_o = q.store;
	assign overflow_o = q.overflow;
	assign store_buf_o = q.sbuf;
	assign irq_o = |(q.irq_stat & q.irq_mask);

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_frame_reserved;
		frame_valid_i && sel_c == MSEL_RSVD;
	endsequence

	sequence s_type_mismatch;
		frame_valid_i && sel_c != MSEL_RSVD && mode_c
			&& frame_i.ide != filter_i.filter_extended_enable;
	endsequence

	sequence s_write_select;
		req_i.wr && req_i.addr == OFS_MASK_SELECT;
	endsequence

	sequence s_read_select;
		req_i.rd && req_i.addr == OFS_MASK_SELECT;
	endsequence

	a_reserved_rejects: assert property (s_frame_reserved |=> !accept_o)
		else $error("reserved mask code accepted a frame");

	// the written word is kept in a local so the read that follows has a reference
	property p_select_readback;
		logic [15:0] v;
		(s_write_select, v = req_i.wdata) ##1 s_read_select |=> rdata_o == v;
	endproperty

	a_select_readback: assert property (p_select_readback)
		else $error("mask select read back differs from write");

	a_sid_unimpl_zero: assert property (
		req_i.rd && (req_i.addr == OFS_MASK0_SID || req_i.addr == OFS_MASK1_SID
			|| req_i.addr == OFS_MASK2_SID) |=> rdata_o[4] == 1'b0 && rdata_o[2] == 1'b0)
		else $error("unimplemented mask bit read as one");

	a_type_mode: assert property (s_type_mismatch |=> !accept_o)
		else $error("frame of wrong type accepted in type mode");

	a_store_sets_full: assert property (store_o |-> q.full[store_buf_o] && !overflow_o)
		else $error("stored buffer not marked full");

	a_full_sticky: assert property (
		$fell(q.full[0]) |-> $past(req_i.wr && req_i.addr == OFS_FULL_LOW
			&& !req_i.wdata[0] && !set_full[0]))
		else $error("full flag dropped without software clear");

	a_full_high_clear: assert property (
		req_i.wr && req_i.addr == OFS_FULL_HIGH && !req_i.wdata[15] && !set_full[31]
			|=> !q.full[31])
		else $error("buffer 31 full flag not cleared by bit 15");

	a_ovf_on_full: assert property (
		frame_valid_i && hit_c && q.full[target_buf_i]
			|=> overflow_o && !store_o ##0 q.ovf[store_buf_o])
		else $error("hit on full buffer did not raise overflow");

	a_ovf_sticky: assert property (
		$fell(q.ovf[16]) |-> $past(req_i.wr && req_i.addr == OFS_OVF_HIGH
			&& !req_i.wdata[0] && !set_ovf[16]))
		else $error("overflow flag dropped without software clear");

	a_set_beats_clear: assert property (
		set_full[0] && req_i.wr && req_i.addr == OFS_FULL_LOW |=> q.full[0])
		else $error("hardware set lost against software clear");

	// flag words are clear-only, so a falling flag must trace back to one of these writes
	sequence s_write_full;
		req_i.wr && (req_i.addr == OFS_FULL_LOW || req_i.addr == OFS_FULL_HIGH);
	endsequence

	sequence s_write_ovf;
		req_i.wr && (req_i.addr == OFS_OVF_LOW || req_i.addr == OFS_OVF_HIGH);
	endsequence

	sequence s_hit_empty;
		frame_valid_i && hit_c && !q.full[target_buf_i];
	endsequence

	sequence s_hit_full;
		frame_valid_i && hit_c && q.full[target_buf_i];
	endsequence

	sequence s_open_mask;
		frame_valid_i && sel_c != MSEL_RSVD && q.msid[sel_c] == 16'h0000
			&& q.meid[sel_c] == 16'h0000;
	endsequence

	a_full_only_cleared: assert property (
		(q.full & ~d.full) != '0 |-> s_write_full)
		else $error("full flag cleared without a flag write");

	a_ovf_only_cleared: assert property (
		(q.ovf & ~d.ovf) != '0 |-> s_write_ovf)
		else $error("overflow flag cleared without a flag write");

	a_hit_empty_stores: assert property (
		s_hit_empty |=> accept_o && store_o && !overflow_o)
		else $error("hit on empty buffer was not stored");

	a_hit_buf_number: assert property (
		frame_valid_i && hit_c |=> store_buf_o == $past(target_buf_i))
		else $error("reported buffer differs from target");

	a_idle_no_pulse: assert property (
		!frame_valid_i |=> !accept_o && !store_o && !overflow_o)
		else $error("result pulse without a frame");

	a_buf_holds: assert property (
		!hit_c |=> $stable(store_buf_o))
		else $error("buffer number moved without an accept");

	a_hit_full_no_store: assert property (
		s_hit_full |=> accept_o && !store_o)
		else $error("hit on full buffer was stored");

	// with no clear in the same cycle both flags of that buffer must stand afterwards
	a_ovf_keeps_full: assert property (
		s_hit_full ##0 !req_i.wr |=> q.full[store_buf_o] && q.ovf[store_buf_o])
		else $error("overflow lost full or overflow flag");

	a_reserved_no_flags: assert property (
		s_frame_reserved |=> !store_o && !overflow_o)
		else $error("reserved mask code changed a buffer");

	a_open_mask_accepts: assert property (
		s_open_mask |=> accept_o)
		else $error("all-clear mask rejected a frame");

	a_std_sid_match: assert property (
		frame_valid_i && sel_c != MSEL_RSVD && !frame_i.ide && !mode_c
			&& ((frame_i.standard_identifier ^ filter_i.standard_identifier) & q.msid[sel_c][15:5]) == 11'h000
			|=> accept_o)
		else $error("standard frame with masked match rejected");

	a_mask_bits_held: assert property (
		(q.msid[0] & ~MSID_IMPL) == 16'h0000 && (q.msid[1] & ~MSID_IMPL) == 16'h0000
			&& (q.msid[2] & ~MSID_IMPL) == 16'h0000)
		else $error("unimplemented mask bit stored");

	a_select_write: assert property (
		s_write_select |=> q.msel == $past(req_i.wdata))
		else $error("mask select write lost");

	a_full_low_read: assert property (
		req_i.rd && req_i.addr == OFS_FULL_LOW |=> rdata_o == $past(q.full[15:0]))
		else $error("low full word read wrong");

	a_full_high_read: assert property (
		req_i.rd && req_i.addr == OFS_FULL_HIGH |=> rdata_o == $past(q.full[31:16]))
		else $error("high full word read wrong");

	a_ovf_low_read: assert property (
		req_i.rd && req_i.addr == OFS_OVF_LOW |=> rdata_o == $past(q.ovf[15:0]))
		else $error("low overflow word read wrong");

	a_ovf_high_read: assert property (
		req_i.rd && req_i.addr == OFS_OVF_HIGH |=> rdata_o == $past(q.ovf[31:16]))
		else $error("high overflow word read wrong");

	a_store_irq: assert property (
		store_o |-> q.irq_stat[IRQ_STORED_BIT])
		else $error("store did not raise its status bit");

	a_ovf_irq: assert property (
		overflow_o |-> q.irq_stat[IRQ_OVF_BIT])
		else $error("overflow did not raise its status bit");

	// the bus has no valid qualifier, so idle read data must be zero
	a_read_one_cycle: assert property (
		!req_i.rd |=> rdata_o == 16'h0000)
		else $error("read data outlived its cycle");

	a_no_frame_no_set: assert property (
		!frame_valid_i |-> set_full == '0 && set_ovf == '0)
		else $error("flag set without a frame");

	a_ovf_low_clear: assert property (
		req_i.wr && req_i.addr == OFS_OVF_LOW && !req_i.wdata[3] && !set_ovf[3]
			|=> !q.ovf[3])
		else $error("buffer 3 overflow flag not cleared");

endmodule
`default_nettype wire

// >>> can_frame_node.sv
// behavioural remote node that hands received frames to the acceptance logic
`timescale 1ns/1ps
`default_nettype none
module can_frame_node
	import can_rx_mask_pkg::*;
(
	input wire logic clk_i,
	input wire logic send_i,
	input wire can_rx_mask_pkg::frame_t frame_i,
	output logic valid_o = 1'b0,
	output can_rx_mask_pkg::frame_t frame_o = '0
);
	// identifier lines toggle between frames so a stale value never passes for a fresh one
	always_ff @(posedge clk_i) begin
		valid_o <= send_i;
		if (send_i) begin
			frame_o <= frame_i;
		end else begin
			frame_o <= ~frame_o;
		end
	end
endmodule
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the receive mask and buffer status unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import can_rx_mask_pkg::*;
	typedef struct packed {
		logic [1:0] code;
		logic [2:0] fnum;
		logic [15:0] msid;
		logic [15:0] meid;
		frame_t fr;
		filter_t fl;
		logic acc;
	} row_t;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	reg_req_t req = '0;
	logic send = 1'b0;
	frame_t fr_src = '0;
	frame_t frame;
	logic fvalid;
	logic [2:0] fnum = '0;
	filter_t flt = '0;
	logic [4:0] tbuf = '0;
	logic [15:0] rdata;
	logic [4:0] sbuf;
	logic acc, sto, ovf, irq;
	int err_total = 0;
	int checks = 0;
	int cyc = 0;
	row_t rows [8];
	always #25 mclk_i = ~mclk_i;
	can_frame_node can_frame_node_inst (.clk_i(mclk_i), .send_i(send), .frame_i(fr_src),
		.valid_o(fvalid), .frame_o(frame));
	can_rx_mask_buf can_rx_mask_buf_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(req),
		.rdata_o(rdata), .frame_valid_i(fvalid), .frame_i(frame), .filter_num_i(fnum),
		.filter_i(flt), .target_buf_i(tbuf), .accept_o(acc), .store_o(sto),
		.overflow_o(ovf), .store_buf_o(sbuf), .irq_o(irq));
	task automatic final_report;
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// the gap edge between strobes keeps each request a single-cycle pulse
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk_i);
		req <= '{1'b1, 1'b0, a, d};
		@(posedge mclk_i);
		req <= '0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge mclk_i);
		req <= '{1'b0, 1'b1, a, 16'h0000};
		@(posedge mclk_i);
		req <= '0;
		#1 chk(rdata, exp);
	endtask
	// exp holds accept, store, overflow
	task automatic rx(input frame_t f, input filter_t l, input logic [2:0] n,
		input logic [4:0] b, input logic [2:0] exp);
		@(posedge mclk_i);
		send <= 1'b1;
		fr_src <= f;
		flt <= l;
		fnum <= n;
		tbuf <= b;
		@(posedge mclk_i);
		send <= 1'b0;
		@(posedge mclk_i);
		#1 chk({13'h0000, acc, sto, ovf}, {13'h0000, exp});
	endtask
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			final_report;
		end
	end
	initial begin
		rows[0] = '{2'h0, 3'h0, 16'hFFE0, 16'h0000, '{1'b0, 11'h123, 18'h0}, '{1'b0, 11'h123, 18'h0}, 1'b1};
		rows[1] = '{2'h1, 3'h7, 16'hFFE0, 16'h0000, '{1'b0, 11'h122, 18'h0}, '{1'b0, 11'h123, 18'h0}, 1'b0};
		rows[2] = '{2'h2, 3'h3, 16'h0000, 16'h0000, '{1'b0, 11'h122, 18'h0}, '{1'b0, 11'h123, 18'h0}, 1'b1};
		rows[3] = '{2'h0, 3'h1, 16'h0008, 16'h0000, '{1'b0, 11'h005, 18'h0}, '{1'b1, 11'h005, 18'h0}, 1'b0};
		rows[4] = '{2'h1, 3'h2, 16'h0008, 16'h0000, '{1'b1, 11'h005, 18'h1}, '{1'b1, 11'h005, 18'h0}, 1'b1};
		rows[5] = '{2'h2, 3'h4, 16'h0003, 16'h0000, '{1'b1, 11'h000, 18'h20000}, '0, 1'b0};
		rows[6] = '{2'h0, 3'h5, 16'h0000, 16'hFFFF, '{1'b1, 11'h000, 18'h1}, '0, 1'b0};
		rows[7] = '{2'h3, 3'h6, 16'h0000, 16'h0000, '0, '0, 1'b0};
		repeat (4) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		rd(OFS_MASK_SELECT, 16'h0000);
		rd(OFS_FULL_HIGH, 16'h0000);
		rd(OFS_OVF_LOW, 16'h0000);
		// the reserved code has no mask set, so its writes land on the flag words as zeros
		foreach (rows[i]) begin
			wr(OFS_MASK_SELECT, {14'h0000, rows[i].code} << (2 * rows[i].fnum));
			wr(4'(1 + 2 * rows[i].code), rows[i].msid);
			wr(4'(2 + 2 * rows[i].code), rows[i].meid);
			rx(rows[i].fr, rows[i].fl, rows[i].fnum, 5'(i), {rows[i].acc, rows[i].acc, 1'b0});
			wr(OFS_FULL_LOW, 16'h0000);
		end
		wr(OFS_MASK0_SID, 16'hFFFF);
		rd(OFS_MASK0_SID, 16'hFFEB);
		wr(OFS_MASK0_SID, 16'h0000);
		wr(OFS_MASK0_EID, 16'h0000);
		wr(OFS_MASK_SELECT, 16'h0000);
		wr(OFS_IRQ_STATUS, 16'h0003);
		wr(OFS_IRQ_MASK, 16'h0003);
		#1 chk({15'h0000, irq}, 16'h0000);
		rx('0, '0, 3'h0, 5'd17, 3'b110);
		chk({11'h000, sbuf}, 16'h0011);
		chk({15'h0000, irq}, 16'h0001);
		rx('0, '0, 3'h0, 5'd17, 3'b101);
		rd(OFS_FULL_HIGH, 16'h0002);
		rd(OFS_OVF_HIGH, 16'h0002);
		rx('0, '0, 3'h0, 5'd3, 3'b110);
		rd(OFS_FULL_LOW, 16'h0008);
		wr(OFS_FULL_HIGH, 16'hFFFF);
		rd(OFS_FULL_HIGH, 16'h0002);
		wr(OFS_OVF_HIGH, 16'h0000);
		rd(OFS_OVF_HIGH, 16'h0000);
		rd(OFS_IRQ_STATUS, 16'h0003);
		wr(OFS_IRQ_STATUS, 16'h0003);
		#1 chk({15'h0000, irq}, 16'h0000);
		wr(OFS_IRQ_MASK, 16'h0000);
		rx('0, '0, 3'h0, 5'd3, 3'b101);
		chk({15'h0000, irq}, 16'h0000);
		rd(OFS_OVF_LOW, 16'h0008);
		rd(OFS_IRQ_STATUS, 16'h0002);
		rd(4'hD, 16'h0000);
		final_report;
	end
endmodule
`default_nettype wire
